// ---- rtl/rssm_pkg.sv ----
// package for the reset sources and supply monitor block
// assumes a single 40 MHz system clock
package rssm_pkg;
	// clock rate and power-on release delay
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned POR_DELAY_US    = 100;
	localparam int unsigned POR_DELAY_CYC   =
		(POR_DELAY_US * (CLK_HZ / 1000000) < 1) ? 1 :
		POR_DELAY_US * (CLK_HZ / 1000000);
	// watchdog prescale after reset
	localparam int unsigned WDT_DIV         = 12;
	// reset values
	localparam logic [7:0]  PORT_LATCH_RST  = 8'hff;
	localparam logic [15:0] PC_RST          = 16'h0000;
	localparam logic [7:0]  SP_RST          = 8'h07;
	localparam logic        CLK_SEL_INTOSC  = 1'b0;
	localparam logic        MON_EN_RST      = 1'b1;
	localparam logic        MON_SEL_RST     = 1'b1;
	localparam logic        HIGH_THR_RST    = 1'b0;
	// sequencer states
	typedef enum logic [1:0] {
		RSSM_HOLD,
		RSSM_DELAY,
		RSSM_RUN
	} rssm_state_t;
endpackage

// ---- rtl/rssm_core.sv ----
// reset sequencer with power-on delay and two supply monitors
// assumes synchronous inputs on sys_clk; supply comparator is external
`timescale 1ns/1ps
`default_nettype none
module rssm_core #(
	parameter int unsigned POR_CYCLES = rssm_pkg::POR_DELAY_CYC
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,            // power-on event
	input  wire logic         supply_ok,      // supply above release level
	input  wire logic         other_reset,    // software/other reset request
	input  wire logic         flash_op,       // flash erase or write attempt
	input  wire logic         ctl_wr,         // supply_monitor_control write
	input  wire logic         ctl_mon_en,     // supply_monitor_enable data
	input  wire logic         ctl_high_thr,   // high_threshold_select data
	input  wire logic         cause_wr,       // reset_cause_register write
	input  wire logic         cause_flag,     // power_on_flag bit data
	output logic              core_reset,     // combined internal reset
	output logic              rst_pin_low_oe, // drive reset pin low
	output logic              power_on_flag,
	output logic              mon_enable,     // standard monitor enabled
	output logic              mon_high_thr,   // high threshold selected
	output logic              mon_selected,   // standard monitor as source
	output logic              lvl_mon_enable, // level monitor enable
	output logic              flash_error,    // flash-error reset pulse
	output logic [7:0]        port_latch,
	output logic              port_open_drain,
	output logic              weak_pullup_en,
	output logic [15:0]       pc_init,
	output logic [7:0]        sp_init,
	output logic              clk_sel,
	output logic              wdt_enable,
	output logic              wdt_tick,
	output logic              intr_timer_off, // interrupts and timers off
	output logic              mem_clear_ok    // data memory undefined
);
	import rssm_pkg::*;

	// how a reset travels through this block:
	// - rst is the power-up event; it loads every register and marks the
	//   reset as a power-up, so the release pays the extra delay
	// - a low supply_ok is a brownout; it holds the sequencer in hold and
	//   drives the reset pin, but recovery after run skips the power-up delay
	// - other_reset and the internal flash-error pulse are plain resets;
	//   they keep the monitor settings and the data memory contents
	// - the core sees one combined reset, core_reset, from a flop, so
	//   every source shows up one edge late; with synchronous inputs
	//   this is the price of glitch-free outputs
	// limitation: the supply comparator and its threshold are outside;
	// both monitors share the one supply_ok input here, so the high
	// threshold bit is only reported and used to gate flash work

	rssm_state_t state_q;                      // hold, delay or run
	logic [$clog2(POR_CYCLES+1)-1:0] cnt_q;    // power-on delay counter
	logic [3:0]                      div_q;    // watchdog prescaler
	logic                            por_q;    // this reset is power-on
	logic                            flash_err_q;

	// a low supply trips the core whether or not the standard monitor is enabled and selected
	logic mon_trip;
	assign mon_trip = !supply_ok && ((mon_enable && mon_selected) || 1'b1);
	// level monitor always trips; standard shares the same threshold here

	// flash is safe only with monitor enabled, high, and selected
	logic flash_bad;
	assign flash_bad = flash_op &&
		!(mon_enable && mon_high_thr && mon_selected);

	// sequencer: hold, optional power-on delay, run
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= RSSM_HOLD;
			cnt_q   <= '0;
			por_q   <= 1'b1;
		end else if (mon_trip) begin
			state_q <= RSSM_HOLD;
			// a brownout after run is a supply reset, not a power-up;
			// a dip inside the power-up delay keeps the power-up path
			if (state_q == RSSM_RUN) begin
				por_q <= 1'b0;
			end
		end else if (other_reset || flash_err_q) begin
			// plain reset: no delay on release, memory kept
			state_q <= RSSM_HOLD;
			por_q   <= 1'b0;
		end else begin
			case (state_q)
				RSSM_HOLD: begin
					// only a power-up pays the extra delay
					state_q <= por_q ? RSSM_DELAY : RSSM_RUN;
					cnt_q   <= '0;
				end
				RSSM_DELAY: begin
					if (cnt_q == ($bits(cnt_q))'(POR_CYCLES - 1)) begin
						state_q <= RSSM_RUN;
					end
					cnt_q <= cnt_q + 1'b1;
				end
				RSSM_RUN: begin
					// stay here until a source pulls us back to hold
					state_q <= RSSM_RUN;
				end
				default: begin
					state_q <= RSSM_HOLD;
				end
			endcase
		end
	end

	// flash-error reset request, a one-cycle pulse into the sequencer;
	// the same pulse is shown on flash_error from its own flop so that
	// the output does not depend on the internal copy
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flash_err_q <= 1'b0;
			flash_error <= 1'b0;
		end else begin
			flash_err_q <= flash_bad && (state_q == RSSM_RUN);
			flash_error <= flash_bad && (state_q == RSSM_RUN);
		end
	end

	// reset outputs; any source sends core_reset high next edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_reset     <= 1'b1;
			rst_pin_low_oe <= 1'b1;
			intr_timer_off <= 1'b1;
		end else begin
			core_reset     <= (state_q != RSSM_RUN) || mon_trip ||
				other_reset || flash_err_q;
			// pin drive only for power-on and supply resets
			rst_pin_low_oe <= mon_trip ||
				(por_q && state_q != RSSM_RUN);
			intr_timer_off <= (state_q != RSSM_RUN);
		end
	end

	// monitor control; enable survives every reset but power-on
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mon_enable   <= MON_EN_RST;
			mon_high_thr <= HIGH_THR_RST;
			mon_selected <= MON_SEL_RST;
		end else if (ctl_wr && state_q == RSSM_RUN) begin
			mon_enable   <= ctl_mon_en;
			mon_high_thr <= ctl_high_thr;
		end
		if (!rst && cause_wr && state_q == RSSM_RUN) begin
			// software must set the flag bit to keep the source selected
			mon_selected <= cause_flag;
		end
	end

	// level monitor: forced on after every reset, no write reaches it;
	// there is deliberately no control input for it at all
	always_ff @(posedge sys_clk) begin
		lvl_mon_enable <= 1'b1;
	end

	// power-on flag: set by power-up, cleared by any other reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			power_on_flag <= 1'b1;
		end else if (other_reset || flash_err_q ||
			(mon_trip && state_q == RSSM_RUN)) begin
			power_on_flag <= 1'b0;
		end
	end

	// memory: only a power-up may be treated as loss of contents
	always_ff @(posedge sys_clk) begin
		mem_clear_ok <= rst || (por_q && state_q != RSSM_RUN);
	end

	// core init values held during reset; stack pointer always reloads
	always_ff @(posedge sys_clk) begin
		if (rst || core_reset) begin
			port_latch      <= PORT_LATCH_RST;
			port_open_drain <= 1'b1;
			pc_init         <= PC_RST;
			sp_init         <= SP_RST;
			clk_sel         <= CLK_SEL_INTOSC;
		end
		weak_pullup_en <= 1'b1;
	end

	// watchdog on with a divide-by-twelve tick once reset ends
	always_ff @(posedge sys_clk) begin
		if (rst || core_reset) begin
			div_q      <= '0;
			wdt_tick   <= 1'b0;
			wdt_enable <= 1'b1;
		end else begin
			wdt_tick <= (div_q == 4'(WDT_DIV - 1));
			div_q    <= (div_q == 4'(WDT_DIV - 1)) ? '0 : div_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- sim/rssm_core_properties.sv ----
// port checks for the reset sequencer
// assumes all ports are sampled on sys_clk
`timescale 1ns/1ps
`default_nettype none
module rssm_core_properties
	import rssm_pkg::*;
(
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic	supply_ok,
	input wire logic	other_reset,
	input wire logic	core_reset,
	input wire logic	rst_pin_low_oe,
	input wire logic	power_on_flag,
	input wire logic	mon_enable,
	input wire logic	mon_selected,
	input wire logic	lvl_mon_enable,
	input wire logic [7:0]	port_latch,
	input wire logic [15:0]	pc_init,
	input wire logic	clk_sel,
	input wire logic	wdt_enable,
	input wire logic	wdt_tick,
	input wire logic	intr_timer_off
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	pin_on_dip_a: assert property (
		!supply_ok |=> rst_pin_low_oe && core_reset)
		else $error("reset pin not driven on low supply");
	lvl_mon_on_a: assert property (
		lvl_mon_enable)
		else $error("level monitor off");
	flag_after_por_a: assert property (
		$fell(rst) |-> power_on_flag && mon_enable && mon_selected)
		else $error("power-on state missing");
	flag_clear_a: assert property (
		other_reset |-> ##[1:3] !power_on_flag)
		else $error("power-on flag kept");
	latch_in_reset_a: assert property (
		core_reset && $past(core_reset) |->
		port_latch == PORT_LATCH_RST)
		else $error("port latch not all ones");
	halt_in_reset_a: assert property (
		core_reset && $past(core_reset) |-> intr_timer_off)
		else $error("interrupts live in reset");
	exit_state_a: assert property (
		!core_reset |-> pc_init == PC_RST &&
		clk_sel == CLK_SEL_INTOSC && wdt_enable)
		else $error("bad state after reset");
	wdt_period_a: assert property (
		wdt_tick ##1 !core_reset[*8] ##1 !core_reset[*3] |=> wdt_tick)
		else $error("watchdog tick period");
	release_sync_a: assert property (
		$fell(core_reset) |-> supply_ok && $past(supply_ok))
		else $error("release with supply low");
endmodule
bind rssm_core rssm_core_properties u_chk (.sys_clk, .rst, .supply_ok,
	.other_reset, .core_reset, .rst_pin_low_oe, .power_on_flag,
	.mon_enable, .mon_selected, .lvl_mon_enable, .port_latch, .pc_init,
	.clk_sel, .wdt_enable, .wdt_tick, .intr_timer_off);
`default_nettype wire

// ---- sim/rssm_supply_model.sv ----
// supply comparator model for the reset sequencer
// assumes the bench requests dips in clock cycles
`timescale 1ns/1ps
`default_nettype none
module rssm_supply_model (
	input wire logic	sys_clk,
	input wire logic	dip_req,	// bench asks for a brownout
	output logic	supply_ok
);
	initial supply_ok = 1'b1;
	// comparator output moves off the sampling edge
	always @(negedge sys_clk) supply_ok <= !dip_req;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the reset sequencer
// assumes a short power-on delay of 10 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rssm_pkg::*;
	localparam int unsigned PC = 10;	// shortened power-on delay
	logic	sys_clk, rst, supply_ok, dip_req, other_reset, flash_op;
	logic	ctl_wr, ctl_mon_en, ctl_high_thr, cause_wr, cause_flag;
	logic	core_reset, rst_pin_low_oe, power_on_flag, mon_enable;
	logic	mon_high_thr, mon_selected, lvl_mon_enable, port_open_drain;
	logic	weak_pullup_en, clk_sel, wdt_enable, wdt_tick, intr_timer_off;
	logic	mem_clear_ok, flash_error;
	logic [7:0]	port_latch, sp_init;
	logic [15:0]	pc_init;
	int	error_cnt, n_tests, k;
	rssm_supply_model u_sup (.sys_clk, .dip_req, .supply_ok);
	rssm_core #(.POR_CYCLES(PC)) dut (.sys_clk, .rst, .supply_ok, .other_reset,
		.flash_op, .ctl_wr, .ctl_mon_en, .ctl_high_thr, .cause_wr, .cause_flag,
		.core_reset, .rst_pin_low_oe, .power_on_flag, .mon_enable, .mon_high_thr,
		.mon_selected, .lvl_mon_enable, .flash_error, .port_latch,
		.port_open_drain, .weak_pullup_en, .pc_init, .sp_init, .clk_sel,
		.wdt_enable, .wdt_tick, .intr_timer_off, .mem_clear_ok);
	task chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task results;
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for core_reset to reach v; k counts cycles
	task wait_cr(input logic v, input int n);
		for (k = 0; k < n && core_reset !== v; k++) @(negedge sys_clk);
		if (core_reset !== v) begin
			chk(1'b0, "reset wait ran out");
			results();
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge sys_clk) s = 1'b1;
		@(negedge sys_clk) s = 1'b0;
	endtask
	task por_seq;
		chk(mem_clear_ok && core_reset && rst_pin_low_oe, "por");
		wait_cr(1'b0, 40);
		chk(k >= PC, "released before delay");
		chk(power_on_flag && mon_enable && mon_selected, "por");
		chk(!mem_clear_ok, "mem flag after run");
		chk(pc_init === PC_RST && sp_init === SP_RST, "exit");
		chk(clk_sel === CLK_SEL_INTOSC, "exit clock");
	endtask
	task dip_seq;
		@(negedge sys_clk) dip_req = 1'b1;
		wait_cr(1'b1, 4);
		repeat (20) @(negedge sys_clk);
		chk(core_reset && rst_pin_low_oe, "dip");
		chk(port_open_drain && weak_pullup_en, "dip pins");
		dip_req = 1'b0;
		wait_cr(1'b0, 6);
	endtask
	task keep_seq;
		ctl_mon_en = 1'b0;
		pulse(ctl_wr);
		pulse(other_reset);
		wait_cr(1'b1, 4);
		chk(!mem_clear_ok, "memory kept");
		wait_cr(1'b0, 40);
		chk(!mon_enable && !power_on_flag, "kept");
		chk(lvl_mon_enable === 1'b1, "level monitor");
	endtask
	task flash_seq;
		pulse(flash_op);
		chk(flash_error === 1'b1, "flash error pulse");
		wait_cr(1'b1, 4);
		wait_cr(1'b0, 40);
		{ctl_mon_en, ctl_high_thr, cause_flag} = 3'h7;
		pulse(ctl_wr);
		pulse(cause_wr);
		pulse(flash_op);
		chk(flash_error === 1'b0, "false flash error");
		repeat (4) @(negedge sys_clk);
		chk(!core_reset && mon_high_thr, "safe flash");
		chk(mon_selected === 1'b1, "monitor selected");
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		{rst, dip_req, other_reset, flash_op, ctl_wr} = 5'h10;
		{ctl_mon_en, ctl_high_thr, cause_wr, cause_flag} = 4'h0;
		error_cnt = 0;
		n_tests = 0;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		por_seq();
		dip_seq();
		keep_seq();
		flash_seq();
		results();
	end
endmodule
`default_nettype wire
